// ### hw/bas_pkg.sv
`default_nettype none
package bas_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_FRONT_END_CONFIG = 8'h00;
    localparam logic [7:0] REG_APPLICATION_CONFIG = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RESULT = 8'h10;
    localparam logic [7:0] REG_SAMPLE = 8'h14;
    // Field positions
    localparam int GAIN_LSB = 0;
    localparam int RANGE_SHIFT_LSB = 4;
    localparam int RESOLUTION_BIT = 6;
    localparam int REFERENCE_SELECT_BIT = 0;
    localparam int TEMP_ENABLE_BIT = 1;
    localparam int OFFSET_ENABLE_BIT = 2;
    localparam int START_BIT = 0;
    // Reset values
    localparam logic [31:0] FRONT_END_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] APPLICATION_CONFIG_RESET = 32'h0000_0006;
    // Counts
    localparam int GAIN_SETTINGS = 9;
    localparam int STARTUP_CONVERSIONS = 5;
    localparam int OSC_DIVIDE = 2;
    localparam int RES_LOW = 13;
    localparam int RES_HIGH = 14;
    typedef enum logic [1:0] {MUX_BRIDGE, MUX_TEMPERATURE, MUX_OFFSET} bas_mux_type;
    typedef enum {ST_IDLE, ST_STARTUP, ST_NORMAL} bas_state_type;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### hw/bas_conv_if.sv
`default_nettype none
interface bas_conv_if;
    logic start;
    logic high_res;
    logic [1:0] range_shift_code;
    logic [14:0] sample;
    logic busy;
    logic done;
    logic signed [15:0] result;
    modport ctrl (output start, high_res, range_shift_code, sample, input busy, done, result);
    modport conv (input start, high_res, range_shift_code, sample, output busy, done, result);
endinterface
`default_nettype wire

// ### hw/bas_converter.sv
`default_nettype none
module bas_converter (
    input wire logic clk,
    input wire logic rst,
    bas_conv_if.conv cv
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic phase;
    logic next_phase;
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;
    logic signed [15:0] result;
    logic signed [15:0] next_result;
    logic [14:0] full;
    logic [14:0] shift;

    assign cv.busy = busy;
    assign cv.done = done;
    assign cv.result = result;

    always_comb
    begin
        full = cv.high_res ? 15'h4000 : 15'h2000;
        shift = full >> (4 - cv.range_shift_code);
        next_count = count;
        next_phase = phase;
        next_busy = busy;
        next_done = 1'b0;
        next_result = result;
        if (!busy && cv.start)
        begin
            next_busy = 1'b1;
            next_phase = 1'b0;
            next_count = {1'b0, full} - 16'h0001;
        end
        else if (busy)
        begin
            // Half oscillator rate: count advances every other clock
            next_phase = ~phase;
            if (phase)
            begin
                if (count == 16'h0000)
                begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    // Sample is already scaled to full scale of the selected resolution
                    next_result = $signed({1'b0, cv.sample}) - $signed({1'b0, shift});
                end
                else
                begin
                    next_count = count - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= 16'h0000;
            phase <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            result <= 16'sh0000;
        end
        else
        begin
            count <= next_count;
            phase <= next_phase;
            busy <= next_busy;
            done <= next_done;
            result <= next_result;
        end
    end
endmodule
`default_nettype wire

// ### hw/bas_axi_slave.sv
`default_nettype none
module bas_axi_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [7:0] aw_addr;
    logic [7:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic b_pend;
    logic next_b_pend;
    logic [1:0] b_code;
    logic [1:0] next_b_code;
    logic r_pend;
    logic next_r_pend;
    logic [31:0] r_data;
    logic [31:0] next_r_data;
    logic [1:0] r_code;
    logic [1:0] next_r_code;

    assign awready = !aw_held && !b_pend;
    assign wready = !w_held && !b_pend;
    assign arready = !r_pend;
    assign bvalid = b_pend;
    assign bresp = b_code;
    assign rvalid = r_pend;
    assign rdata = r_data;
    assign rresp = r_code;
    assign wr_addr = aw_addr;
    assign wr_data = w_data;
    assign wr_strb = w_strb;
    assign wr_en = aw_held && w_held && !b_pend;
    assign rd_addr = araddr;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_b_pend = b_pend;
        next_b_code = b_code;
        next_r_pend = r_pend;
        next_r_data = r_data;
        next_r_code = r_code;
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (wr_en)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_b_pend = 1'b1;
            next_b_code = wr_err ? bas_pkg::AXI_SLVERR : bas_pkg::AXI_OKAY;
        end
        if (b_pend && bready)
        begin
            next_b_pend = 1'b0;
        end
        if (arvalid && arready)
        begin
            next_r_pend = 1'b1;
            next_r_data = rd_err ? 32'h0000_0000 : rd_data;
            next_r_code = rd_err ? bas_pkg::AXI_SLVERR : bas_pkg::AXI_OKAY;
        end
        else if (r_pend && rready)
        begin
            next_r_pend = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            b_pend <= 1'b0;
            b_code <= 2'h0;
            r_pend <= 1'b0;
            r_data <= 32'h0000_0000;
            r_code <= 2'h0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            b_pend <= next_b_pend;
            b_code <= next_b_code;
            r_pend <= next_r_pend;
            r_data <= next_r_data;
            r_code <= next_r_code;
        end
    end
endmodule
`default_nettype wire

// ### hw/bas_sequencer.sv
// Contract
// - Front-end gain selectable among exactly nine settings from 105 down to 2.8.
// - Sensor offset removed digitally by the calibration controller, not analog trim.
// - Multiplexer steps bridge, temperature, internal offset per stored configuration.
// - After power-on a startup routine runs before the repeating normal cycle.
// - Converter resolution is 13 or 14 bits, nothing else.
// - Conversion lasts two to the resolution periods of half oscillator clock.
// - Result equals full scale times input over reference minus range shift.
// - Reference select bit: 0 bridge top-to-bottom, 1 analog supply.
// - Range-shift field selects 1/16, 1/8, 1/4 or 1/2 of full scale.
// - Digital output resolution equals converter resolution; analog path gives 12 bits.
// - Startup routine takes five conversion times before normal cycling.
`default_nettype none
module bas_sequencer (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [14:0] ADC_SAMPLE,
    output logic [3:0] GAIN_SELECT,
    output logic [1:0] MUX_SELECT,
    output logic ADC_REFERENCE_SELECT,
    output logic ADC_BUSY,
    output logic NORMAL_CYCLE,
    output logic RESULT_VALID,
    output logic signed [15:0] ADC_RESULT,
    output logic [11:0] ANALOG_CODE
);
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic [31:0] front_end_config_word;
    logic [31:0] next_front_end_config_word;
    logic [31:0] application_config_word;
    logic [31:0] next_application_config_word;
    logic run;
    logic next_run;
    bas_pkg::bas_state_type state;
    bas_pkg::bas_state_type next_state;
    bas_pkg::bas_mux_type mux;
    bas_pkg::bas_mux_type next_mux;
    logic [2:0] startup_count;
    logic [2:0] next_startup_count;
    logic launched;
    logic next_launched;
    logic [31:0] cycle_count;
    logic [31:0] next_cycle_count;
    logic signed [15:0] last_result;
    logic signed [15:0] next_last_result;
    logic valid;
    logic next_valid;
    logic [11:0] analog;
    logic [11:0] next_analog;
    logic [3:0] gain;
    logic high_res;
    logic [1:0] shift_code;
    bas_conv_if cv ();

    function automatic logic reg_known(input logic [7:0] a);
        reg_known = (a == bas_pkg::REG_FRONT_END_CONFIG) || (a == bas_pkg::REG_APPLICATION_CONFIG) ||
            (a == bas_pkg::REG_CONTROL) || (a == bas_pkg::REG_STATUS) ||
            (a == bas_pkg::REG_RESULT) || (a == bas_pkg::REG_SAMPLE);
    endfunction

    // Next multiplexer channel; disabled optional channels are skipped
    function automatic bas_pkg::bas_mux_type next_channel(input bas_pkg::bas_mux_type m,
        input logic temp_en, input logic off_en);
        case (m)
            bas_pkg::MUX_BRIDGE: next_channel = temp_en ? bas_pkg::MUX_TEMPERATURE :
                (off_en ? bas_pkg::MUX_OFFSET : bas_pkg::MUX_BRIDGE);
            bas_pkg::MUX_TEMPERATURE: next_channel = off_en ? bas_pkg::MUX_OFFSET : bas_pkg::MUX_BRIDGE;
            default: next_channel = bas_pkg::MUX_BRIDGE;
        endcase
    endfunction

    bas_axi_slave u_axi (
        .clk(CLK),
        .rst(SYS_RST),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    bas_converter u_conv (
        .clk(CLK),
        .rst(SYS_RST),
        .cv(cv.conv)
    );

    assign gain = front_end_config_word[bas_pkg::GAIN_LSB +: 4];
    assign shift_code = front_end_config_word[bas_pkg::RANGE_SHIFT_LSB +: 2];
    assign high_res = front_end_config_word[bas_pkg::RESOLUTION_BIT];

    assign cv.high_res = high_res;
    assign cv.range_shift_code = shift_code;
    // Input scaled to the selected full scale; 13-bit mode drops the LSB
    assign cv.sample = high_res ? ADC_SAMPLE : {1'b0, ADC_SAMPLE[14:1]};
    assign cv.start = run && !cv.busy && !launched;

    assign GAIN_SELECT = gain;
    assign MUX_SELECT = mux;
    assign ADC_REFERENCE_SELECT = application_config_word[bas_pkg::REFERENCE_SELECT_BIT];
    assign ADC_BUSY = cv.busy;
    assign NORMAL_CYCLE = (state == bas_pkg::ST_NORMAL);
    assign RESULT_VALID = valid;
    assign ADC_RESULT = last_result;
    assign ANALOG_CODE = analog;

    // Gain codes beyond the nine settings are refused
    assign wr_err = !reg_known(wr_addr) || (wr_addr == bas_pkg::REG_FRONT_END_CONFIG && wr_strb[0] &&
        wr_data[bas_pkg::GAIN_LSB +: 4] >= 4'(bas_pkg::GAIN_SETTINGS));
    assign rd_err = !reg_known(rd_addr);

    always_comb
    begin
        case (rd_addr)
            bas_pkg::REG_FRONT_END_CONFIG: rd_data = front_end_config_word;
            bas_pkg::REG_APPLICATION_CONFIG: rd_data = application_config_word;
            bas_pkg::REG_CONTROL: rd_data = {31'h0, run};
            bas_pkg::REG_STATUS: rd_data = {26'h0, mux, cv.busy, valid, state == bas_pkg::ST_NORMAL,
                state == bas_pkg::ST_STARTUP};
            bas_pkg::REG_RESULT: rd_data = {{16{last_result[15]}}, last_result};
            bas_pkg::REG_SAMPLE: rd_data = cycle_count;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        next_front_end_config_word = front_end_config_word;
        next_application_config_word = application_config_word;
        next_run = run;
        next_state = state;
        next_mux = mux;
        next_startup_count = startup_count;
        next_launched = launched;
        next_cycle_count = cycle_count;
        next_last_result = last_result;
        next_valid = valid;
        next_analog = analog;
        if (wr_en && !wr_err && wr_strb[0])
        begin
            if (wr_addr == bas_pkg::REG_FRONT_END_CONFIG)
                next_front_end_config_word = {25'h0, wr_data[6:0]};
            else if (wr_addr == bas_pkg::REG_APPLICATION_CONFIG)
                next_application_config_word = {29'h0, wr_data[2:0]};
            else if (wr_addr == bas_pkg::REG_CONTROL)
                next_run = wr_data[bas_pkg::START_BIT];
        end
        if (cv.start)
            next_launched = 1'b1;
        case (state)
            bas_pkg::ST_IDLE:
            begin
                if (run)
                begin
                    next_state = bas_pkg::ST_STARTUP;
                    next_startup_count = 3'h0;
                    next_mux = bas_pkg::MUX_BRIDGE;
                end
            end
            bas_pkg::ST_STARTUP:
            begin
                if (cv.done)
                begin
                    next_launched = 1'b0;
                    next_mux = next_channel(mux, 1'b1, 1'b1);
                    if (startup_count == 3'(bas_pkg::STARTUP_CONVERSIONS - 1))
                    begin
                        next_state = bas_pkg::ST_NORMAL;
                        next_mux = bas_pkg::MUX_BRIDGE;
                    end
                    else
                        next_startup_count = startup_count + 3'h1;
                end
            end
            bas_pkg::ST_NORMAL:
            begin
                if (cv.done)
                begin
                    next_launched = 1'b0;
                    next_mux = next_channel(mux, application_config_word[bas_pkg::TEMP_ENABLE_BIT],
                        application_config_word[bas_pkg::OFFSET_ENABLE_BIT]);
                    if (!run)
                        next_state = bas_pkg::ST_IDLE;
                end
            end
            default: next_state = bas_pkg::ST_IDLE;
        endcase
        if (cv.done)
        begin
            next_cycle_count = cycle_count + 32'h1;
            // Offset is removed later in software conditioning, so raw counts pass unchanged
            if (mux == bas_pkg::MUX_BRIDGE)
            begin
                next_last_result = cv.result;
                // Analog path keeps only 12 bits at either resolution
                next_analog = high_res ? cv.result[13:2] : cv.result[12:1];
                next_valid = (state == bas_pkg::ST_NORMAL);
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            front_end_config_word <= bas_pkg::FRONT_END_CONFIG_RESET;
            application_config_word <= bas_pkg::APPLICATION_CONFIG_RESET;
            run <= 1'b1;
            state <= bas_pkg::ST_IDLE;
            mux <= bas_pkg::MUX_BRIDGE;
            startup_count <= 3'h0;
            launched <= 1'b0;
            cycle_count <= 32'h0;
            last_result <= 16'sh0000;
            valid <= 1'b0;
            analog <= 12'h000;
        end
        else
        begin
            front_end_config_word <= next_front_end_config_word;
            application_config_word <= next_application_config_word;
            run <= next_run;
            state <= next_state;
            mux <= next_mux;
            startup_count <= next_startup_count;
            launched <= next_launched;
            cycle_count <= next_cycle_count;
            last_result <= next_last_result;
            valid <= next_valid;
            analog <= next_analog;
        end
    end
endmodule
`default_nettype wire

// ### testbench/bas_adc_source.sv
`default_nettype none
module bas_adc_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] mux_select,
    output logic [14:0] sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [14:0] next_sample;
    // Bridge sits at 75% of range, so the full resolution is reachable
    always_comb
    begin
        case (mux_select)
            2'h0: next_sample = 15'h3000;
            2'h1: next_sample = 15'h2000;
            2'h2: next_sample = 15'h0100;
            default: next_sample = ~sample;
        endcase
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sample <= 15'h5555;
        else
            sample <= next_sample;
    end
endmodule
`default_nettype wire

// ### testbench/bas_seq_properties.sv
`default_nettype none
module bas_seq_properties (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] GAIN_SELECT,
    input wire logic [1:0] MUX_SELECT,
    input wire logic ADC_BUSY,
    input wire logic NORMAL_CYCLE,
    input wire logic RESULT_VALID,
    input wire logic signed [15:0] ADC_RESULT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    logic [15:0] busy_len;
    logic [15:0] next_busy_len;
    always_comb
    begin
        next_busy_len = ADC_BUSY ? busy_len + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            busy_len <= 16'h0000;
        else
            busy_len <= next_busy_len;
    end
    a_gain_legal: assert property (GAIN_SELECT <= 4'h8) else $error("gain code out of range");
    a_mux_legal: assert property (MUX_SELECT != 2'h3) else $error("unused mux code");
    a_mux_steady: assert property (ADC_BUSY [*3] |-> $stable(MUX_SELECT)) else $error("mux moved mid conversion");
    a_valid_normal: assert property ($rose(RESULT_VALID) |-> $past(NORMAL_CYCLE)) else $error("result before startup");
    a_conv_short: assert property ($fell(ADC_BUSY) |-> busy_len >= 16'h4000) else $error("conversion too short");
    a_conv_long: assert property (ADC_BUSY |-> busy_len <= 16'h8004) else $error("conversion too long");
    a_result_span: assert property (RESULT_VALID |-> ADC_RESULT >= -16'sh2000 && ADC_RESULT <= 16'sh3fff)
        else $error("result wider than converter");
    a_result_moment: assert property ($changed(ADC_RESULT) |-> !ADC_BUSY || !$past(ADC_BUSY) || !$past(ADC_BUSY, 2))
        else $error("result changed mid conversion");
endmodule
bind bas_sequencer bas_seq_properties u_props (.CLK(CLK), .SYS_RST(SYS_RST), .GAIN_SELECT(GAIN_SELECT),
    .MUX_SELECT(MUX_SELECT), .ADC_BUSY(ADC_BUSY), .NORMAL_CYCLE(NORMAL_CYCLE), .RESULT_VALID(RESULT_VALID),
    .ADC_RESULT(ADC_RESULT));
`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, gain;
    logic [1:0] bresp, rresp, mux;
    logic [14:0] sample;
    logic ref_sel, busy, normal, valid;
    logic signed [15:0] result;
    logic [11:0] analog;
    int errors;
    int num_checks;
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    bas_sequencer DUT (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ADC_SAMPLE(sample),
        .GAIN_SELECT(gain), .MUX_SELECT(mux), .ADC_REFERENCE_SELECT(ref_sel), .ADC_BUSY(busy),
        .NORMAL_CYCLE(normal), .RESULT_VALID(valid), .ADC_RESULT(result), .ANALOG_CODE(analog));
    bas_adc_source u_src (.clk(clk), .rst(rst), .mux_select(mux), .sample(sample));
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic timeout();
        errors++;
        wrap_up();
    endtask
    // Both channels offered together; each dropped only when taken
    task automatic write_check(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (n == 50)
            timeout();
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    task automatic read_check(input string name, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (n == 50)
            timeout();
        check(name, rdata, ed);
        check("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    task automatic t_reset_values();
        check("ref_sel", {31'h0, ref_sel}, 32'h0);
        read_check("fe", bas_pkg::REG_FRONT_END_CONFIG, bas_pkg::FRONT_END_CONFIG_RESET, bas_pkg::AXI_OKAY);
        read_check("app", bas_pkg::REG_APPLICATION_CONFIG, bas_pkg::APPLICATION_CONFIG_RESET, bas_pkg::AXI_OKAY);
        read_check("hole", 8'h40, 32'h0, bas_pkg::AXI_SLVERR);
    endtask
    task automatic t_config();
        logic [31:0] v;
        for (int g = 0; g < bas_pkg::GAIN_SETTINGS; g++)
        begin
            v = 32'(g) | (32'(g % 4) << bas_pkg::RANGE_SHIFT_LSB) | (32'(g % 2) << bas_pkg::RESOLUTION_BIT);
            write_check(bas_pkg::REG_FRONT_END_CONFIG, v, bas_pkg::AXI_OKAY);
            read_check("fe", bas_pkg::REG_FRONT_END_CONFIG, v, bas_pkg::AXI_OKAY);
        end
        write_check(bas_pkg::REG_FRONT_END_CONFIG, 32'h9, bas_pkg::AXI_SLVERR);
        read_check("fe_kept", bas_pkg::REG_FRONT_END_CONFIG, v, bas_pkg::AXI_OKAY);
        write_check(bas_pkg::REG_FRONT_END_CONFIG, 32'h35, bas_pkg::AXI_OKAY);
        write_check(bas_pkg::REG_APPLICATION_CONFIG, 32'h7, bas_pkg::AXI_OKAY);
        write_check(8'h40, 32'h1, bas_pkg::AXI_SLVERR);
    endtask
    // Startup takes five 13-bit conversions; only one normal result fits the run
    task automatic t_startup();
        logic [1:0] seq[$];
        logic [1:0] exp_seq[5];
        int len;
        int n;
        logic prev;
        logic seen;
        exp_seq = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
        len = 0;
        prev = 1'b0;
        seen = 1'b0;
        for (n = 0; n < 90000 && normal !== 1'b1; n++)
        begin
            @(posedge clk);
            if (busy === 1'b1 && !prev)
                seq.push_back(mux);
            // The first conversion began before this task, so the second one is timed whole
            if (busy === 1'b1 && seq.size() == 2)
                len++;
            prev = busy;
        end
        if (normal !== 1'b1)
            timeout();
        check("starts", seq.size(), 32'(bas_pkg::STARTUP_CONVERSIONS));
        check("conv_len", 32'(len >= 16384 && len <= 16390), 32'h1);
        for (int i = 0; i < 5; i++)
            check("mux_seq", {30'h0, seq[i]}, {30'h0, exp_seq[i]});
        for (n = 0; n < 20000 && valid !== 1'b1; n++)
        begin
            @(posedge clk);
            if (busy === 1'b1 && !seen)
            begin
                check("mux_normal", {30'h0, mux}, 32'h0);
                seen = 1'b1;
            end
        end
        if (valid !== 1'b1)
            timeout();
        check("result", 32'(result), 32'((15'h3000 >> 1) - (1 << (bas_pkg::RES_LOW - 1))));
        check("analog", {20'h0, analog}, 32'h400);
        check("gain_out", {28'h0, gain}, 32'h5);
        check("ref_out", {31'h0, ref_sel}, 32'h1);
        read_check("result_reg", bas_pkg::REG_RESULT, 32'h800, bas_pkg::AXI_OKAY);
    endtask
    initial
    begin
        errors = 0;
        num_checks = 0;
        {awvalid, wvalid, arvalid} = 3'h0;
        // Response readies stay high, so back-to-back tasks never drive them twice in one step
        {bready, rready} = 2'h3;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_config();
        t_startup();
        wrap_up();
    end
endmodule
`default_nettype wire
